// ---- tae_pkg.sv ----
// Constants shared by the temperature alarm and event logic
// How it works
// - Limits hold 10 bits, 0.25 degree step
// - Reading holds 12 bits, 0.0625 degree step
// - All temperatures use two's complement
// - Bit 12 is sign; limit bits 15..13 zero
// - Reading bit 15: temperature at/above critical
// - Reading bit 14: temperature above high
// - Reading bit 13: temperature below low
// - Unsupported resolution bits read zero
// - Limit bits 1 and 0 always zero
// - Interrupt mode latches crossings until cleared
// - Above critical, alert holds, no clear
// - Clear above critical waits until below
// - Comparator mode: alert outside alarm window
// - Critical-only mode: alert above critical only
// - Clears ignored in comparator, critical-only
// - Trip points from limits plus hysteresis
// - Shutdown stops, freezes reading and alert
// - Reading updates only on samples
// - Limit writes re-evaluate alert at once
// - Critical-only bit restricts events to critical
// - Clear bit acts in interrupt mode, reads zero
// - Polarity bit: zero low, one high
// - Hysteresis codes: 0, 1.5, 3, 6 degrees
package tae_pkg;
  // Register pointer values
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_LOW = 4'h3;
  localparam logic [3:0] ADDR_CRIT = 4'h4;
  localparam logic [3:0] ADDR_READING = 4'h5;
  // Configuration field positions
  localparam int CFG_HYSTERESIS_SELECT_LO = 9;
  localparam int CFG_HYSTERESIS_SELECT_HI = 10;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_ALARM_LOCK = 6;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_STATUS = 4;
  localparam int CFG_OUT_EN = 3;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_POLARITY = 1;
  localparam int CFG_INT_MODE = 0;
  // Temperature field layout
  localparam int TEMP_W = 13;
  localparam int LIMIT_LSB = 2;
  localparam int READ_CRIT = 15;
  localparam int READ_HIGH = 14;
  localparam int READ_LOW = 13;
  // Reset values
  localparam logic [12:0] LIMIT_RESET = 13'h0000;
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  localparam logic [1:0] HYSTERESIS_SELECT_RESET = 2'h0;
  // Hysteresis in reading steps of 0.0625 degree, 14 bits signed
  localparam logic [13:0] HYSTERESIS_SELECT_OFF = 14'h0000;
  localparam logic [13:0] HYSTERESIS_SELECT_1P5 = 14'h0018;
  localparam logic [13:0] HYSTERESIS_SELECT_3P0 = 14'h0030;
  localparam logic [13:0] HYSTERESIS_SELECT_6P0 = 14'h0060;
  // Resolution capability codes and their reading masks
  localparam logic [1:0] RES_9BIT = 2'h0;
  localparam logic [1:0] RES_10BIT = 2'h1;
  localparam logic [1:0] RES_11BIT = 2'h2;
  localparam logic [1:0] RES_12BIT = 2'h3;
  localparam logic [12:0] MASK_9BIT = 13'h1FF8;
  localparam logic [12:0] MASK_10BIT = 13'h1FFC;
  localparam logic [12:0] MASK_11BIT = 13'h1FFE;
  localparam logic [12:0] MASK_12BIT = 13'h1FFF;
endpackage : tae_pkg

// ---- tae_limit_reg.sv ----
// One lockable 10-bit trip limit register
`timescale 1ns/10ps
module tae_limit_reg (
  input wire logic i_clock, // System clock
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_wr_en, // Write strobe, lock already applied
  input wire logic [15:0] i_wdata, // Write data from host
  output logic [12:0] o_value, // Signed limit, 0.0625 step
  output logic [15:0] o_rdata // Read-back image
);
  // Only the eleven magnitude-plus-sign bits are stored
  logic [10:0] value_r; // Bits 12..2 of the limit
  logic [10:0] value_nxt; // Next stored bits

  // Writes take bits 12..2; low bits never stored
  assign value_nxt = i_wr_en ? i_wdata[12:tae_pkg::LIMIT_LSB] : value_r;

  // Trailing zeros fill bits 1..0 whatever the sign
  assign o_value = {value_r, 2'b00};
  // Top three bits read zero, sign in bit 12
  assign o_rdata = {3'b000, o_value};

  // Storage
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      value_r <= tae_pkg::LIMIT_RESET[12:2];
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule : tae_limit_reg

// ---- tae_alarm.sv ----
// Temperature reading, limit compare and alert pin logic
`timescale 1ns/10ps
module tae_alarm #(
  parameter logic [1:0] RES_CAP = 2'h3 // Resolution capability code
) (
  input wire logic i_clock, // System clock, 50 MHz
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_reg_wr, // Register write strobe, one cycle
  input wire logic [3:0] i_reg_addr, // Register pointer
  input wire logic [15:0] i_reg_wdata, // Register write data
  output logic [15:0] o_reg_rdata, // Registered read data
  input wire logic i_sample_valid, // Converter sample strobe
  input wire logic [12:0] i_sample_temp, // Converter sample, signed
  output logic o_conv_enable, // Converter run request
  output logic o_alert_out, // Alert pin drive value
  output logic o_alert_oe // Alert pin drive enable
);
  // Pointer and data come from the serial front end on this
  // clock, so no synchroniser is needed here
  // Address decode
  // Writes to other pointers fall through and are lost
  wire cfg_wr; // Configuration write
  wire high_wr_sel; // High limit addressed
  wire low_wr_sel; // Low limit addressed
  wire crit_wr_sel; // Critical limit addressed
  assign cfg_wr = i_reg_wr && (i_reg_addr == tae_pkg::ADDR_CONFIG);
  assign high_wr_sel = i_reg_wr && (i_reg_addr == tae_pkg::ADDR_HIGH);
  assign low_wr_sel = i_reg_wr && (i_reg_addr == tae_pkg::ADDR_LOW);
  assign crit_wr_sel = i_reg_wr && (i_reg_addr == tae_pkg::ADDR_CRIT);

  // Configuration state
  logic [1:0] hysteresis_select_r; // Hysteresis select
  logic shutdown_r; // Shutdown control
  logic crit_lock_r; // Critical limit lock
  logic alarm_lock_r; // Alarm limits lock
  logic out_enable_r; // Alert output enable
  logic crit_only_r; // Critical-only select
  logic polarity_r; // Alert polarity
  logic int_mode_r; // Interrupt mode when set
  // Next values, one per configuration field
  logic [1:0] hysteresis_select_nxt;
  logic shutdown_nxt;
  logic crit_lock_nxt;
  logic alarm_lock_nxt;
  logic out_enable_nxt;
  logic crit_only_nxt;
  logic polarity_nxt;
  logic int_mode_nxt;

  // Locks guard limits and modes against stray host writes
  // Status bit is read-only; writes to it are dropped
  // Either lock freezes the mode fields
  wire lock_any; // Some lock is set
  wire mode_wr; // Mode fields may change
  assign lock_any = crit_lock_r || alarm_lock_r;
  assign mode_wr = cfg_wr && !lock_any;

  // Mode fields follow the write unless locked
  assign hysteresis_select_nxt = mode_wr ?
    i_reg_wdata[tae_pkg::CFG_HYSTERESIS_SELECT_HI:tae_pkg::CFG_HYSTERESIS_SELECT_LO] : hysteresis_select_r;
  assign out_enable_nxt = mode_wr ?
    i_reg_wdata[tae_pkg::CFG_OUT_EN] : out_enable_r;
  assign polarity_nxt = mode_wr ?
    i_reg_wdata[tae_pkg::CFG_POLARITY] : polarity_r;
  assign int_mode_nxt = mode_wr ?
    i_reg_wdata[tae_pkg::CFG_INT_MODE] : int_mode_r;

  // Shutdown clears any time but sets only unlocked
  // A locked part may still be woken, never put to sleep
  wire sd_bit; // Shutdown bit as written
  assign sd_bit = i_reg_wdata[tae_pkg::CFG_SHUTDOWN];
  assign shutdown_nxt = !cfg_wr ? shutdown_r :
    (!sd_bit ? 1'b0 : (lock_any ? shutdown_r : 1'b1));

  // Critical-only cannot be set under the alarm lock
  wire co_bit; // Critical-only bit as written
  assign co_bit = i_reg_wdata[tae_pkg::CFG_CRIT_ONLY];
  assign crit_only_nxt = (cfg_wr && !(co_bit && alarm_lock_r)) ?
    co_bit : crit_only_r;

  // Locks are sticky until reset
  // There is no unlock write; only reset lifts a lock
  assign crit_lock_nxt = crit_lock_r ||
    (cfg_wr && i_reg_wdata[tae_pkg::CFG_CRIT_LOCK]);
  assign alarm_lock_nxt = alarm_lock_r ||
    (cfg_wr && i_reg_wdata[tae_pkg::CFG_ALARM_LOCK]);

  // Configuration registers
  // Reset leaves comparator mode, pin disabled, active low
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      hysteresis_select_r <= tae_pkg::HYSTERESIS_SELECT_RESET;
      shutdown_r <= 1'b0;
      crit_lock_r <= 1'b0;
      alarm_lock_r <= 1'b0;
      out_enable_r <= 1'b0;
      crit_only_r <= 1'b0;
      polarity_r <= 1'b0;
      int_mode_r <= 1'b0;
    end else begin
      hysteresis_select_r <= hysteresis_select_nxt;
      shutdown_r <= shutdown_nxt;
      crit_lock_r <= crit_lock_nxt;
      alarm_lock_r <= alarm_lock_nxt;
      out_enable_r <= out_enable_nxt;
      crit_only_r <= crit_only_nxt;
      polarity_r <= polarity_nxt;
      int_mode_r <= int_mode_nxt;
    end
  end

  // Limit registers; locks gate the write strobes
  // Values are signed in reading steps; images are for read-back
  // One instance per limit keeps the lock gating visible
  logic [12:0] high_val; // High limit value
  logic [12:0] low_val; // Low limit value
  logic [12:0] crit_val; // Critical limit value
  logic [15:0] high_rd; // High limit read image
  logic [15:0] low_rd; // Low limit read image
  logic [15:0] crit_rd; // Critical limit read image

  // High alarm limit
  tae_limit_reg u_high (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_wr_en(high_wr_sel && !alarm_lock_r),
    .i_wdata(i_reg_wdata),
    .o_value(high_val),
    .o_rdata(high_rd)
  );

  // Low alarm limit
  tae_limit_reg u_low (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_wr_en(low_wr_sel && !alarm_lock_r),
    .i_wdata(i_reg_wdata),
    .o_value(low_val),
    .o_rdata(low_rd)
  );

  // Critical limit
  tae_limit_reg u_crit (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_wr_en(crit_wr_sel && !crit_lock_r),
    .i_wdata(i_reg_wdata),
    .o_value(crit_val),
    .o_rdata(crit_rd)
  );

  // Bits below the supported resolution are forced to zero
  // Capability is fixed at build time, so this folds to a constant
  wire [12:0] res_mask; // Mask for the capability
  assign res_mask =
    (RES_CAP == tae_pkg::RES_9BIT) ? tae_pkg::MASK_9BIT :
    (RES_CAP == tae_pkg::RES_10BIT) ? tae_pkg::MASK_10BIT :
    (RES_CAP == tae_pkg::RES_11BIT) ? tae_pkg::MASK_11BIT :
    tae_pkg::MASK_12BIT;

  // Reading moves only on a sample, never in shutdown
  // A sample in shutdown is dropped, not kept for later
  logic [12:0] temp_r; // Recorded temperature
  logic [12:0] temp_nxt;
  assign temp_nxt = (i_sample_valid && !shutdown_r) ?
    (i_sample_temp & res_mask) : temp_r;

  // Recorded temperature
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      temp_r <= tae_pkg::TEMP_RESET;
    end else begin
      temp_r <= temp_nxt;
    end
  end

  // Sign-extend to 14 bits so limit minus hysteresis cannot wrap
  // Limits carry two zero bits, so one scale serves all compares
  wire signed [13:0] t_s; // Temperature
  wire signed [13:0] hi_s; // High limit
  wire signed [13:0] lo_s; // Low limit
  wire signed [13:0] cr_s; // Critical limit
  assign t_s = {temp_r[12], temp_r};
  assign hi_s = {high_val[12], high_val};
  assign lo_s = {low_val[12], low_val};
  assign cr_s = {crit_val[12], crit_val};

  // Hysteresis amount in reading steps
  // Offsets are even step counts, so masking never shifts them
  // Code zero falls through to no offset
  wire signed [13:0] hysteresis_select_s; // Selected offset
  assign hysteresis_select_s =
    (hysteresis_select_r == 2'h1) ? tae_pkg::HYSTERESIS_SELECT_1P5 :
    (hysteresis_select_r == 2'h2) ? tae_pkg::HYSTERESIS_SELECT_3P0 :
    (hysteresis_select_r == 2'h3) ? tae_pkg::HYSTERESIS_SELECT_6P0 : tae_pkg::HYSTERESIS_SELECT_OFF;

  // Raw compares feed the reading flags directly
  // Status bits skip hysteresis so the host sees the plain compare
  wire crit_raw; // At or above critical
  wire high_raw; // Above high
  wire low_raw; // Below low
  assign crit_raw = (t_s >= cr_s);
  assign high_raw = (t_s > hi_s);
  assign low_raw = (t_s < lo_s);

  // Release points sit one hysteresis inside each limit
  // The extra sign bit keeps limits near the range end from wrapping
  wire signed [13:0] cr_rel; // Critical release point
  wire signed [13:0] hi_rel; // High release point
  wire signed [13:0] lo_rel; // Low release point
  assign cr_rel = cr_s - hysteresis_select_s;
  assign hi_rel = hi_s - hysteresis_select_s;
  assign lo_rel = lo_s + hysteresis_select_s;

  // Trip flags; hysteresis only on the way out
  // Shutdown freezes the flags so the alert keeps its last state
  logic crit_trip_r; // Critical tripped
  logic high_trip_r; // High tripped
  logic low_trip_r; // Low tripped
  logic crit_trip_nxt;
  logic high_trip_nxt;
  logic low_trip_nxt;
  // Compares run every cycle, so limit writes act at once
  assign crit_trip_nxt = shutdown_r ? crit_trip_r :
    (crit_trip_r ? !(t_s < cr_rel) : crit_raw);
  assign high_trip_nxt = shutdown_r ? high_trip_r :
    (high_trip_r ? !(t_s <= hi_rel) : high_raw);
  assign low_trip_nxt = shutdown_r ? low_trip_r :
    (low_trip_r ? !(t_s >= lo_rel) : low_raw);

  // Alarm window crossing in either direction is an event
  // Critical crossings never latch an event; the critical flag
  // holds the alert directly instead
  wire alarm_cross; // High or low flag changed
  assign alarm_cross = !crit_only_r &&
    ((high_trip_nxt != high_trip_r) ||
     (low_trip_nxt != low_trip_r));

  // Clears only count in plain interrupt mode
  // A clear in other modes is dropped, not remembered
  wire clear_req; // Clear bit written as one
  wire clear_ok; // Mode accepts clears
  wire clear_now; // Clear acted on this cycle
  wire clear_defer; // Clear held for later
  wire clear_exec; // Clear takes effect
  assign clear_req = cfg_wr && i_reg_wdata[tae_pkg::CFG_CLEAR];
  assign clear_ok = int_mode_r && !crit_only_r;
  assign clear_now = clear_req && clear_ok && !crit_trip_r;
  assign clear_defer = clear_req && clear_ok && crit_trip_r;

  // Held clear waits for the critical flag to drop
  // Limitation: a held clear is lost if the mode changes first
  logic pend_r; // Deferred clear waiting
  logic pend_nxt;
  assign pend_nxt = crit_trip_r && (pend_r || clear_defer);
  assign clear_exec = clear_now ||
    (pend_r && !crit_trip_r && clear_ok);

  // Event latch; a crossing wins over a clear in one cycle
  // Set priority keeps a crossing in the clear cycle from being lost
  logic event_r; // Latched interrupt event
  logic event_nxt;
  assign event_nxt = !clear_ok ? 1'b0 :
    (alarm_cross ? 1'b1 :
    (clear_exec ? 1'b0 : event_r));

  // Trip, event and clear state
  // All flags share one reset so they agree after power-up
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      crit_trip_r <= 1'b0;
      high_trip_r <= 1'b0;
      low_trip_r <= 1'b0;
      pend_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      crit_trip_r <= crit_trip_nxt;
      high_trip_r <= high_trip_nxt;
      low_trip_r <= low_trip_nxt;
      pend_r <= pend_nxt;
      event_r <= event_nxt;
    end
  end

  // Alert by mode; frozen state keeps it during shutdown
  // Status and pin share one asserted term, so they never disagree
  wire window_out; // Outside alarm window
  wire alert_c; // Alert condition
  wire asserted; // Enabled alert, polarity free
  assign window_out = high_trip_r || low_trip_r || crit_trip_r;
  assign alert_c = crit_only_r ? crit_trip_r :
    (int_mode_r ? (event_r || crit_trip_r) :
    window_out);
  assign asserted = alert_c && out_enable_r;

  // Open-drain pin: level low means drive, high means release
  // Disabled and active high pulls the line low, like a
  // grounded output
  wire pin_level; // Wanted line level
  assign pin_level = polarity_r ? asserted : !asserted;

  // Pin drive enable from a flop; released at reset
  // Costs one cycle but keeps decode glitches off the shared line
  logic alert_oe_r; // Registered drive enable
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      alert_oe_r <= 1'b0;
    end else begin
      alert_oe_r <= !pin_level;
    end
  end
  // Open drain never drives high
  // Only the enable toggles; the value is tied low
  assign o_alert_out = 1'b0;
  assign o_alert_oe = alert_oe_r;
  // Converter stops in shutdown
  assign o_conv_enable = !shutdown_r;

  // Read images; clear bit and reserved bits read zero
  // Status bit is polarity free and follows the output enable
  wire [15:0] cfg_rd; // Configuration image
  wire [15:0] temp_rd; // Reading image
  wire [15:0] rd_mux; // Selected read data
  assign cfg_rd = {5'b00000, hysteresis_select_r, shutdown_r, crit_lock_r,
    alarm_lock_r, 1'b0, asserted, out_enable_r, crit_only_r,
    polarity_r, int_mode_r};
  assign temp_rd = {crit_raw, high_raw, low_raw, temp_r};
  assign rd_mux =
    (i_reg_addr == tae_pkg::ADDR_CONFIG) ? cfg_rd :
    (i_reg_addr == tae_pkg::ADDR_HIGH) ? high_rd :
    (i_reg_addr == tae_pkg::ADDR_LOW) ? low_rd :
    (i_reg_addr == tae_pkg::ADDR_CRIT) ? crit_rd :
    (i_reg_addr == tae_pkg::ADDR_READING) ? temp_rd : 16'h0000;

  // Read data registered; no read has side effects
  // One cycle of latency: the pointer must lead the data
  logic [15:0] rdata_r; // Read data register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_mux;
    end
  end
  assign o_reg_rdata = rdata_r;
endmodule : tae_alarm

// ---- tae_alarm_sva.sv ----
// Port checker for the temperature alarm block
`timescale 1ns/10ps
module tae_alarm_chk #(
  parameter logic [1:0] RES_CAP = 2'h3 // Resolution capability
) (
  input wire logic i_clock, // Clock
  input wire logic i_reset, // Reset, high
  input wire logic i_reg_wr, // Write strobe
  input wire logic [3:0] i_reg_addr, // Pointer
  input wire logic [15:0] i_reg_wdata, // Write data
  input wire logic [15:0] o_reg_rdata, // Read data
  input wire logic i_sample_valid, // Sample strobe
  input wire logic [12:0] i_sample_temp, // Sample value
  input wire logic o_conv_enable, // Converter run
  input wire logic o_alert_out, // Pin value
  input wire logic o_alert_oe // Pin enable
);
  // Reading bits kept at this capability
  localparam logic [12:0] MSK = (RES_CAP == 2'h0) ? tae_pkg::MASK_9BIT :
    (RES_CAP == 2'h1) ? tae_pkg::MASK_10BIT :
    (RES_CAP == 2'h2) ? tae_pkg::MASK_11BIT : tae_pkg::MASK_12BIT;
  // Pointer decodes
  wire logic is_lim = i_reg_addr inside {4'h2, 4'h3, 4'h4};
  wire logic is_rd = i_reg_addr == tae_pkg::ADDR_READING;
  wire logic is_gap = i_reg_addr == 4'h0 || i_reg_addr > 4'h5;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  chk_limit_pad_bits: assert property (is_lim |=>
    o_reg_rdata[15:13] == 3'h0 && o_reg_rdata[1:0] == 2'h0)
    else $error("limit pad bits set");
  chk_clear_reads_zero: assert property (
    i_reg_addr == tae_pkg::ADDR_CONFIG |=>
    !o_reg_rdata[tae_pkg::CFG_CLEAR] && o_reg_rdata[15:11] == 5'h00)
    else $error("config clear or spare bit set");
  chk_res_mask: assert property (is_rd |=>
    (o_reg_rdata[12:0] & ~MSK) == 13'h0000)
    else $error("unsupported reading bit set");
  chk_sample_lands: assert property (
    (i_sample_valid && o_conv_enable) ##1 is_rd |=>
    o_reg_rdata[12:0] == ($past(i_sample_temp, 2) & MSK))
    else $error("reading differs from sample");
  chk_reading_frozen: assert property (
    (!o_conv_enable && is_rd) [*2] |=> $stable(o_reg_rdata[12:0]))
    else $error("reading moved in shutdown");
  chk_gap_reads_zero: assert property (is_gap |=> o_reg_rdata == 16'h0000)
    else $error("unmapped pointer read nonzero");
  chk_conv_resume: assert property (
    i_reg_wr && i_reg_addr == tae_pkg::ADDR_CONFIG &&
    !i_reg_wdata[tae_pkg::CFG_SHUTDOWN] |=> o_conv_enable)
    else $error("converter not restarted");
  chk_alert_frozen: assert property (
    (!o_conv_enable && !i_reg_wr) [*4] |=> $stable(o_alert_oe))
    else $error("alert moved in shutdown");
endmodule : tae_alarm_chk

bind tae_alarm tae_alarm_chk #(.RES_CAP(RES_CAP)) chk_u (
  .i_clock(i_clock), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_sample_valid(i_sample_valid),
  .i_sample_temp(i_sample_temp), .o_conv_enable(o_conv_enable),
  .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe));

// ---- tae_conv_model.sv ----
// Converter model feeding samples to the alarm block
`timescale 1ns/10ps
module tae_conv_model (
  input wire logic i_clock, // Clock
  input wire logic i_reset, // Reset, high
  input wire logic i_conv_enable, // Run request
  input wire logic [12:0] i_target, // Temperature to report
  output logic o_valid = 1'b0, // Sample strobe
  output logic [12:0] o_temp = 13'h0000 // Sample value
);
  logic [1:0] cnt_r = 2'h0; // Sample spacing
  logic [12:0] last_r = 13'h0000; // Last value sent
  // One sample every four cycles, none while stopped
  always @(negedge i_clock) begin
    if (i_reset) begin
      cnt_r <= 2'h0;
      o_valid <= 1'b0;
    end else if (i_conv_enable && cnt_r == 2'h3) begin
      cnt_r <= 2'h0;
      o_valid <= 1'b1;
      o_temp <= i_target;
      last_r <= i_target;
    end else begin
      // Idle bus shows junk so a stale value never passes
      cnt_r <= i_conv_enable ? cnt_r + 2'h1 : cnt_r;
      o_valid <= 1'b0;
      o_temp <= ~last_r;
    end
  end
endmodule : tae_conv_model

// ---- testbench.sv ----
// Self-checking bench for the temperature alarm block
`timescale 1ns/10ps
module testbench;
  localparam logic [1:0] RES = 2'h2; // 11-bit, drops bit 0
  localparam logic [3:0] CFG = tae_pkg::ADDR_CONFIG; // Short alias
  localparam logic [3:0] HI = tae_pkg::ADDR_HIGH; // Short alias
  localparam logic [3:0] RD = tae_pkg::ADDR_READING; // Short alias
  logic i_clock = 1'b0; // Clock
  logic i_reset = 1'b1; // Reset
  logic i_reg_wr = 1'b0; // Write strobe
  logic [3:0] i_reg_addr = 4'h0; // Pointer
  logic [15:0] i_reg_wdata = 16'h0000; // Write data
  logic [12:0] target = 13'h0000; // Model temperature
  logic i_sample_valid; // Sample strobe
  logic [12:0] i_sample_temp; // Sample value
  logic [15:0] o_reg_rdata; // Read data
  logic o_conv_enable; // Converter run
  logic o_alert_out; // Pin value
  logic o_alert_oe; // Pin enable
  int fail_count = 0; // Mismatches
  int comparisons = 0; // Compares made
  // Samples and readings: equal, above high, crit, low edge, below, neg
  logic [12:0] tv [6] = '{13'h0190, 13'h0192, 13'h0321, 13'h1E70,
    13'h1E6F, 13'h1FFF};
  logic [15:0] ev [6] = '{16'h0190, 16'h4192, 16'hC320, 16'h1E70,
    16'h3E6E, 16'h1FFE};
  // Hysteresis in 0.0625 degree steps per code
  logic [12:0] hy [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
  tae_alarm #(.RES_CAP(RES)) dut_u (.i_clock(i_clock),
    .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sample_valid(i_sample_valid), .i_sample_temp(i_sample_temp),
    .o_conv_enable(o_conv_enable), .o_alert_out(o_alert_out),
    .o_alert_oe(o_alert_oe));
  tae_conv_model conv_u (.i_clock(i_clock), .i_reset(i_reset),
    .i_conv_enable(o_conv_enable), .i_target(target),
    .o_valid(i_sample_valid), .o_temp(i_sample_temp));
  // Free-running clock
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  task automatic conclude;
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic st(input int n);
    repeat (n) @(negedge i_clock);
  endtask : st
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge i_clock);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(negedge i_clock);
    i_reg_addr = a;
    @(negedge i_clock);
    chk(o_reg_rdata, exp);
  endtask : rc
  // New temperature, then time for sample and pin to settle
  task automatic tp(input logic [12:0] t);
    target = t;
    st(8);
  endtask : tp
  // Pin line is the pull-up unless driven low
  task automatic al(input logic pol, input logic act);
    logic line;
    line = o_alert_oe ? o_alert_out : 1'b1;
    chk({15'h0000, line}, {15'h0000, pol ? act : ~act});
  endtask : al
  task automatic t_regs;
    // Reset reading is zero, which equals the zero critical limit
    for (int a = 0; a < 7; a++)
      rc(a[3:0], (a == 5) ? 16'h8000 : 16'h0000);
    wr(HI, 16'hFFFF);
    rc(HI, 16'h1FFC);
    wr(tae_pkg::ADDR_LOW, 16'hE003);
    rc(tae_pkg::ADDR_LOW, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rc(4'h6, 16'h0000);
    wr(CFG, 16'h0020);
    rc(CFG, 16'h0000);
  endtask : t_regs
  task automatic t_reading;
    wr(HI, 16'h0190);
    wr(tae_pkg::ADDR_LOW, 16'h1E70);
    wr(tae_pkg::ADDR_CRIT, 16'h0320);
    for (int k = 0; k < 6; k++) begin
      tp(tv[k]);
      rc(RD, ev[k]);
    end
  endtask : t_reading
  // Comparator window with every hysteresis code
  task automatic t_compare;
    logic [15:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 16'h0008 | (16'(k) << 9);
      wr(CFG, c);
      tp(13'h0200);
      al(1'b0, 1'b1);
      wr(CFG, c | 16'h0020);
      st(2);
      al(1'b0, 1'b1);
      tp(13'h0192 - hy[k]);
      al(1'b0, 1'b1);
      tp(13'h0190 - hy[k]);
      al(1'b0, 1'b0);
    end
    wr(CFG, 16'h0008);
    tp(13'h1E6E);
    al(1'b0, 1'b1);
    tp(13'h0100);
    wr(HI, 16'h00F0);
    st(2);
    al(1'b0, 1'b1);
    wr(HI, 16'h0190);
    st(2);
    al(1'b0, 1'b0);
  endtask : t_compare
  // Interrupt mode, active high pin
  task automatic t_intr;
    wr(CFG, 16'h000B);
    tp(13'h0200);
    al(1'b1, 1'b1);
    tp(13'h0100);
    al(1'b1, 1'b1);
    wr(CFG, 16'h002B);
    st(2);
    al(1'b1, 1'b0);
    tp(13'h0330);
    al(1'b1, 1'b1);
    wr(CFG, 16'h002B);
    st(2);
    al(1'b1, 1'b1);
    tp(13'h0300);
    al(1'b1, 1'b0);
  endtask : t_intr
  task automatic t_crit;
    wr(CFG, 16'h000D);
    st(2);
    al(1'b0, 1'b0);
    tp(13'h0330);
    al(1'b0, 1'b1);
    wr(CFG, 16'h002D);
    st(2);
    al(1'b0, 1'b1);
    tp(13'h0100);
    al(1'b0, 1'b0);
  endtask : t_crit
  task automatic t_shut;
    wr(CFG, 16'h0008);
    tp(13'h0200);
    wr(CFG, 16'h0108);
    chk({15'h0000, o_conv_enable}, 16'h0000);
    tp(13'h0100);
    rc(RD, 16'h4200);
    al(1'b0, 1'b1);
    // Host releases the shared line while stopped
    wr(CFG, 16'h0100);
    st(2);
    al(1'b0, 1'b0);
    wr(CFG, 16'h0008);
    tp(13'h0100);
    al(1'b0, 1'b0);
  endtask : t_shut
  // Locks, then a reset in mid-run to release them
  task automatic t_lock;
    tp(13'h0000);
    wr(CFG, 16'h00C0);
    wr(HI, 16'h0100);
    rc(HI, 16'h0190);
    wr(CFG, 16'h010B);
    rc(CFG, 16'h00C0);
    chk({15'h0000, o_conv_enable}, 16'h0001);
    i_reset = 1'b1;
    st(2);
    i_reset = 1'b0;
    rc(CFG, 16'h0000);
    rc(RD, 16'h8000);
  endtask : t_lock
  // Main sequence
  initial begin
    st(2);
    i_reset = 1'b0;
    t_regs();
    t_reading();
    t_compare();
    t_intr();
    t_crit();
    t_shut();
    t_lock();
    conclude();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule : testbench
